// [hw/bded_top.sv]
// Back-EMF zero-crossing and end-of-demagnetization event detector.
// Assumes an APB master on clk, phase pins from comparators (asynchronous)
// and PWM sampling strobes from logic on the same clock.
//
// Overview of operation
// - Steps one to six load fixed output patterns
// - Steps select phase inputs C, B, A repeating
// - Odd steps falling edge, even rising edge
// - Demag enables 10 odd steps, 11 even
// - Accelerating drivers 5,0,1,2,3,4 per step
// - Sensor mode bit picks sensor or sensorless
// - Input select routes one phase pin
// - Reference select picks comparator threshold
// - Z sampling: window rate or PWM strobe
// - Demag sampling at fixed 800 kHz
// - Events accepted only in order C, D, Z
// - Edge and level bits classify D versus Z
// - Ignore demag for 20 us after C
// - Ignore zero crossing 20 us after D
// - Hardware demag captures step timer value
// - Software demag fires on timer match
// - First of hardware or software demag wins
// - Demag event sets flag, masked request
// - Eight-bit step timer gives demag references
// - Sensor mode: 800 kHz, no demag, any window
// - Zero crossing sets flag, masked request
// - Group select picks sensing high-side group
`timescale 1ns/1ps
module bded_top #(
	parameter int SAMPLE_CYCLES = bded_pkg::SAMPLE_CYC,
	parameter int BLANK_CYCLES = bded_pkg::BLANK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [bded_pkg::ADDR_W-1:0] paddr,
	input wire logic [bded_pkg::DATA_W-1:0] pwdata,
	output logic [bded_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic phaseInputA,
	input wire logic phaseInputB,
	input wire logic phaseInputC,
	input wire logic pwmSampleStrobe,
	input wire logic pwmOddActive,
	input wire logic pwmEvenActive,
	output logic [5:0] outputPattern,
	output logic [1:0] inputSelect,
	output logic [1:0] referenceSelect,
	output logic [5:0] demagDriver,
	output logic sensorMode,
	output logic demagPulse,
	output logic zeroPulse,
	output logic irqReq
);
	import bded_pkg::*;

	function automatic logic hitOf(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hitOf = (a == ofs);
	endfunction : hitOf

	logic [CTRL_W-1:0] ctrlReg;
	logic [2:0] stepReg;
	logic [5:0] patternReg;
	logic [1:0] iselReg;
	logic [5:0] drvReg;
	logic [7:0] demagReg;
	logic [7:0] timerReg;
	logic [1:0] flagReg;
	logic [1:0] maskReg;
	bded_state_e stateReg;
	logic [10:0] blankReg;
	logic [6:0] sampleCnt;
	logic [6:0] tickGap;
	logic [7:0] winCnt;
	logic [2:0] phSync1;
	logic [2:0] phSync2;
	logic dPrev;
	logic zPrev;
	logic [1:0] flagNext;

	// APB decode
	wire hitCtrl = hitOf(paddr, OFS_CTRL);
	wire hitStep = hitOf(paddr, OFS_STEP);
	wire hitTimer = hitOf(paddr, OFS_TIMER);
	wire hitDemag = hitOf(paddr, OFS_DEMAG);
	wire hitStatus = hitOf(paddr, OFS_STATUS);
	wire hitMask = hitOf(paddr, OFS_MASK);
	wire hitCommute = hitOf(paddr, OFS_COMMUTE);
	wire mapped = hitCtrl | hitStep | hitTimer | hitDemag | hitStatus | hitMask | hitCommute;
	wire accessStart = psel & penable & ~pready;
	wire wrEn = psel & penable & pready & pwrite & mapped;
	wire [2:0] stepIn = pwdata[2:0];
	wire stepValid = (stepIn >= 3'h1) && (stepIn <= 3'h6);
	wire stepWr = wrEn & hitStep & stepValid;
	wire [2:0] stepIdx = stepIn - 3'h1;

	// Control fields
	wire sensorSel = ctrlReg[CTRL_SENSOR];
	wire edgeSel = ctrlReg[CTRL_EDGE];
	wire zLevelSel = ctrlReg[CTRL_ZLEVEL];
	wire hdmEn = ctrlReg[CTRL_HDM];
	wire sdmEn = ctrlReg[CTRL_SDM];
	wire groupSel = ctrlReg[CTRL_GROUP];
	wire currentMode = ctrlReg[CTRL_CURMODE];
	wire [3:0] winRate = ctrlReg[CTRL_WRATE +: 4];

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phSync1 <= 3'h0;
			phSync2 <= 3'h0;
		end else begin
			phSync1 <= {phaseInputC, phaseInputB, phaseInputA};
			phSync2 <= phSync1;
		end
	end

	// Only one phase reaches the event logic; code 3 falls back to A
	wire selSample = (iselReg == 2'h3) ? phSync2[0] : phSync2[iselReg];

	// Fixed 800 kHz sample tick
	wire sampleTick = (sampleCnt == 7'h00);
	always_ff @(posedge clk) begin
		if (!rst_n || sampleTick)
			sampleCnt <= 7'(SAMPLE_CYCLES - 1);
		else
			sampleCnt <= sampleCnt - 7'h01;
	end

	// Measurement window tick for current mode
	wire winTick = (winCnt == 8'h00);
	always_ff @(posedge clk) begin
		if (!rst_n || winTick)
			winCnt <= {winRate, WIN_LOW};
		else
			winCnt <= winCnt - 8'h01;
	end

	// Z sampling source and group gate
	wire zTick = sensorSel ? sampleTick : (currentMode ? winTick : pwmSampleStrobe);
	wire groupOk = groupSel ? pwmOddActive : pwmEvenActive;
	wire zGate = sensorSel | groupOk;

	// Edge classification: D is the opposite swing of Z
	wire zRising = edgeSel ^ zLevelSel;
	wire zEdge = zTick & zGate & (selSample != zPrev) & (selSample == zRising);
	wire dEdge = sampleTick & (selSample != dPrev) & (selSample == ~zRising);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dPrev <= 1'b0;
			zPrev <= 1'b0;
		end else begin
			if (sampleTick)
				dPrev <= selSample;
			if (zTick)
				zPrev <= selSample;
		end
	end

	// Event decisions
	wire blankDone = (blankReg == 11'h000);
	wire commute = wrEn & hitCommute;
	wire dHard = hdmEn & dEdge;
	wire dSoft = sdmEn & (timerReg == demagReg);
	wire dNone = ~hdmEn & ~sdmEn;
	wire inWaitD = (stateReg == ST_WAIT_D);
	wire inWaitZ = (stateReg == ST_WAIT_Z);
	// Either source ends demag; with none enabled the blank alone does
	wire dEvent = ~commute & inWaitD & blankDone & (dHard | dSoft | dNone);
	wire zEvent = ~commute & inWaitZ & blankDone & zEdge;

	always_ff @(posedge clk) begin
		if (!rst_n)
			stateReg <= ST_WAIT_C;
		else if (commute)
			stateReg <= sensorSel ? ST_WAIT_Z : ST_WAIT_D;
		else begin
			case (stateReg)
				ST_WAIT_C: stateReg <= ST_WAIT_C;
				ST_WAIT_D: begin
					if (dEvent)
						stateReg <= ST_WAIT_Z;
				end
				ST_WAIT_Z: begin
					if (zEvent)
						stateReg <= ST_WAIT_C;
				end
				default: stateReg <= ST_WAIT_C;
			endcase
		end
	end

	// Blanking after C and after D
	always_ff @(posedge clk) begin
		if (!rst_n)
			blankReg <= 11'h000;
		else if (commute || dEvent)
			blankReg <= 11'(BLANK_CYCLES);
		else if (!blankDone)
			blankReg <= blankReg - 11'h001;
	end

	// Step timer restarts at each commutation, ticks at the sample rate
	always_ff @(posedge clk) begin
		if (!rst_n || commute)
			timerReg <= 8'h00;
		else if (sampleTick)
			timerReg <= timerReg + 8'h01;
	end

	// Demag register: capture beats a software write in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n)
			demagReg <= DEMAG_RST;
		else if (dEvent && dHard)
			demagReg <= timerReg;
		else if (wrEn && hitDemag)
			demagReg <= pwdata[7:0];
	end

	// Control register; a step write overrides edge and demag enables
	always_ff @(posedge clk) begin
		if (!rst_n)
			ctrlReg <= CTRL_RST;
		else if (wrEn && hitCtrl)
			ctrlReg <= pwdata[CTRL_W-1:0];
		else if (stepWr) begin
			ctrlReg[CTRL_EDGE] <= stepIdx[0];
			ctrlReg[CTRL_HDM] <= 1'b1;
			ctrlReg[CTRL_SDM] <= stepIdx[0];
		end
	end

	// Step configuration
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stepReg <= 3'h0;
			patternReg <= PATTERN_RST;
			iselReg <= 2'h0;
			drvReg <= 6'h00;
		end else if (stepWr) begin
			stepReg <= stepIn;
			patternReg <= PAT_TAB[stepIdx];
			iselReg <= ISEL_TAB[stepIdx];
			drvReg <= DRV_TAB[stepIdx];
		end
	end

	// Sticky flags, write one to clear; a new event wins over the clear
	always_comb begin
		flagNext = flagReg;
		if (wrEn && hitStatus)
			flagNext = flagReg & ~pwdata[1:0];
		if (dEvent)
			flagNext[STAT_DEMAG] = 1'b1;
		if (zEvent)
			flagNext[STAT_ZERO] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flagReg <= 2'h0;
			maskReg <= 2'h0;
		end else begin
			flagReg <= flagNext;
			if (wrEn && hitMask)
				maskReg <= pwdata[1:0];
		end
	end

	// Read mux
	wire [DATA_W-1:0] rdCtrl = {19'h00000, ctrlReg};
	wire [DATA_W-1:0] rdStep = {10'h000, drvReg, 2'h0, patternReg, 2'h0, iselReg, 1'b0, stepReg};
	wire [DATA_W-1:0] rdStatus = {28'h0000000, stateReg, flagReg};
	wire [DATA_W-1:0] rdData =
		hitCtrl ? rdCtrl :
		hitStep ? rdStep :
		hitTimer ? {24'h000000, timerReg} :
		hitDemag ? {24'h000000, demagReg} :
		hitStatus ? rdStatus :
		hitMask ? {30'h00000000, maskReg} : 32'h00000000;

	// One wait state keeps every bus output registered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= accessStart;
			pslverr <= accessStart & ~mapped;
			if (accessStart)
				prdata <= pwrite ? 32'h00000000 : rdData;
		end
	end

	// Registered outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			outputPattern <= PATTERN_RST;
			inputSelect <= 2'h0;
			referenceSelect <= 2'h0;
			demagDriver <= 6'h00;
			sensorMode <= 1'b0;
			demagPulse <= 1'b0;
			zeroPulse <= 1'b0;
			irqReq <= 1'b0;
		end else begin
			outputPattern <= patternReg;
			inputSelect <= iselReg;
			referenceSelect <= ctrlReg[CTRL_REF +: 2];
			demagDriver <= drvReg;
			sensorMode <= sensorSel;
			demagPulse <= dEvent;
			zeroPulse <= zEvent;
			irqReq <= |(flagNext & maskReg);
		end
	end

	// Independent gap count between sample ticks, so the rate check does not reuse sampleCnt
	always_ff @(posedge clk) begin
		if (!rst_n || sampleTick)
			tickGap <= 7'h00;
		else
			tickGap <= tickGap + 7'h01;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_step_pattern: assert property (stepWr && stepIn == 3'h1 |=> ##1 outputPattern == 6'h21)
		else $error("step one pattern wrong");
	chk_step_select: assert property (stepWr && stepIn == 3'h3 |=> ##1 inputSelect == 2'h0)
		else $error("step three input select wrong");
	chk_step_edge: assert property (stepWr |=> edgeSel == ~$past(stepIn[0]))
		else $error("step edge select wrong");
	chk_step_demag: assert property (stepWr |=> hdmEn && (sdmEn == ~$past(stepIn[0])))
		else $error("step demag enables wrong");
	chk_demag_driver: assert property (stepWr && stepIn == 3'h2 |=> ##1 demagDriver == 6'h01)
		else $error("step two demag driver wrong");
	chk_event_order: assert property (zeroPulse |-> $past(stateReg) == ST_WAIT_Z && stateReg == ST_WAIT_C)
		else $error("zero crossing out of order");
	chk_blank_after_c: assert property (commute |=> !dEvent [*8])
		else $error("demag inside blanking");
	chk_blank_after_d: assert property (demagPulse |-> !zeroPulse ##1 !zeroPulse [*8])
		else $error("zero crossing inside blanking");
	chk_hw_capture: assert property (dEvent && dHard |=> demagReg == $past(timerReg))
		else $error("demag capture lost");
	chk_demag_flag: assert property (demagPulse |-> flagReg[STAT_DEMAG])
		else $error("demag flag not set");
	chk_sample_tick: assert property (sampleTick |-> tickGap == 7'(SAMPLE_CYCLES - 1))
		else $error("sample tick period wrong");
	chk_zero_flag: assert property (zeroPulse |-> flagReg[STAT_ZERO])
		else $error("zero crossing flag not set");
	chk_irq_mask: assert property (zeroPulse && $past(maskReg[STAT_ZERO]) |-> irqReq)
		else $error("zero crossing request lost");
	chk_sw_demag: assert property (inWaitD && sdmEn && blankDone && !commute && timerReg == demagReg |=> demagPulse)
		else $error("software demag missed");
	chk_sensor_skip: assert property (commute && sensorSel |=> stateReg == ST_WAIT_Z)
		else $error("sensor mode did not skip demag");
	chk_pattern_pair: assert property (outputPattern != PATTERN_RST |-> $countones(outputPattern) == 2)
		else $error("pattern not one high and one low");
	chk_driver_onehot: assert property (demagDriver != 6'h00 |-> $onehot(demagDriver))
		else $error("demag driver not single");
	chk_zero_group: assert property (zeroPulse && !$past(sensorSel) |-> $past(groupOk))
		else $error("zero crossing outside sensing group");
endmodule : bded_top

// [include/bded_pkg.sv]
// Shared constants for the back-EMF / demagnetization event detector.
// Assumes a 100 MHz clock and an APB master with 32-bit data.
package bded_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STEP = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_TIMER = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DEMAG = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_COMMUTE = 8'h18;

	// Control register fields
	localparam int CTRL_SENSOR = 0;
	localparam int CTRL_REF = 1;
	localparam int CTRL_EDGE = 3;
	localparam int CTRL_ZLEVEL = 4;
	localparam int CTRL_HDM = 5;
	localparam int CTRL_SDM = 6;
	localparam int CTRL_GROUP = 7;
	localparam int CTRL_CURMODE = 8;
	localparam int CTRL_WRATE = 9;
	localparam int CTRL_W = 13;

	// Step register fields (read view)
	localparam int STEP_IDX = 0;
	localparam int STEP_ISEL = 4;
	localparam int STEP_PAT = 8;
	localparam int STEP_DRV = 16;

	// Status fields
	localparam int STAT_DEMAG = 0;
	localparam int STAT_ZERO = 1;
	localparam int STAT_STATE = 2;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
	localparam logic [7:0] DEMAG_RST = 8'hFF;
	localparam logic [5:0] PATTERN_RST = 6'h00;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SAMPLE_PERIOD_NS = 1250;
	localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int BLANK_TIME_US = 20;
	localparam int BLANK_CYC = BLANK_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam logic [3:0] WIN_LOW = 4'hF;

	// Six-step table, index 0 is step one
	localparam logic [5:0] PAT_TAB [0:5] = '{6'h21, 6'h03, 6'h06, 6'h0C, 6'h18, 6'h30};
	localparam logic [1:0] ISEL_TAB [0:5] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0};
	localparam logic [5:0] DRV_TAB [0:5] = '{6'h20, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10};

	typedef enum logic [1:0] {ST_WAIT_C, ST_WAIT_D, ST_WAIT_Z} bded_state_e;
endpackage : bded_pkg

// [verification/bded_motor_model.sv]
// Winding model: comparator view of the non-excited phase of a motor.
// Assumes the bench pulses kick just after each commutation it commands.
`timescale 1ns/1ps
module bded_motor_model (
	input wire logic clk,
	input wire logic [1:0] inputSelect,
	input wire logic kick,
	input wire logic evenStep,
	input wire integer demagDelay,
	input wire integer zeroDelay,
	output logic phaseInputA,
	output logic phaseInputB,
	output logic phaseInputC
);
	int cnt = 100000;
	logic noise = 1'b0;
	logic level;
	// Rail level while demagnetising, star level after, back across at zero crossing
	assign level = (cnt < demagDelay) ? evenStep : (cnt < demagDelay + zeroDelay) ? ~evenStep : evenStep;
	always @(posedge clk) begin
		cnt <= kick ? 0 : (cnt < 100000 ? cnt + 1 : cnt);
		noise <= ~noise;
	end
	// Unselected windings toggle, so a wrong route shows up as false events
	assign phaseInputA = (inputSelect == 2'h0) ? level : noise;
	assign phaseInputB = (inputSelect == 2'h1) ? level : noise;
	assign phaseInputC = (inputSelect == 2'h2) ? level : noise;
endmodule : bded_motor_model

// [verification/bemf_demag_event_detector_tb_top.sv]
// Bench for the event detector: APB tasks, winding model, event timing checks.
// Assumes short count parameters, so blanking is 20 cycles and sampling 4.
`timescale 1ns/1ps
module bemf_demag_event_detector_tb_top;
	import bded_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, errSeen, phaseInputA, phaseInputB, phaseInputC;
	logic pwmSampleStrobe = 0, pwmOddActive = 1, pwmEvenActive = 0;
	logic [5:0] outputPattern, demagDriver;
	logic [1:0] inputSelect, referenceSelect;
	logic sensorMode, demagPulse, zeroPulse, irqReq, kick = 0, evenStep = 0;
	logic [2:0] strobeCnt = 0;
	int demagDelay = 0, zeroDelay = 0, errors = 0, n_tests = 0, tD, tZ;
	always #5 clk = ~clk;
	// Voltage-mode sampling strobe, one pulse in eight cycles
	always @(posedge clk) begin
		strobeCnt <= strobeCnt + 3'h1;
		pwmSampleStrobe <= (strobeCnt == 3'h7);
	end
	bded_top #(.SAMPLE_CYCLES(4), .BLANK_CYCLES(20)) i_bded_top (.clk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .phaseInputA, .phaseInputB, .phaseInputC,
		.pwmSampleStrobe, .pwmOddActive, .pwmEvenActive, .outputPattern, .inputSelect,
		.referenceSelect, .demagDriver, .sensorMode, .demagPulse, .zeroPulse, .irqReq);
	bded_motor_model i_bded_motor_model (.clk, .inputSelect, .kick, .evenStep, .demagDelay, .zeroDelay,
		.phaseInputA, .phaseInputB, .phaseInputC);
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never gets an answer
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic win(input string name, input int v, input int lo, input int hi);
		chk(name, 32'h1, {31'h0, v >= lo && v <= hi});
	endtask : win
	// Commutation, optional demag value written while the timer is still small, then the winding
	task automatic evt(input int dD, input int zD, input int dm);
		demagDelay <= dD;
		zeroDelay <= zD;
		apb(1'b1, OFS_COMMUTE, 32'h0);
		if (dm >= 0) apb(1'b1, OFS_DEMAG, 32'(dm));
		kick <= 1'b1;
		tD = -1;
		tZ = -1;
		@(posedge clk);
		kick <= 1'b0;
		for (int i = 0; i < 600; i++) begin
			@(posedge clk);
			if (demagPulse === 1'b1 && tD < 0) tD = i;
			if (zeroPulse === 1'b1 && tZ < 0) tZ = i;
		end
	endtask : evt
	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	// Tests take about 5000 cycles; the limit leaves a wide margin
	initial begin
		#200000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("pattern reset", 32'h0, {26'h0, outputPattern});
		apb(1'b0, OFS_DEMAG, 32'h0);
		chk("demag reset", {24'h0, DEMAG_RST}, rd);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped", 32'h1, {31'h0, errSeen});
		for (int s = 0; s < 6; s++) begin
			apb(1'b1, OFS_STEP, 32'(s + 1));
			apb(1'b0, OFS_STEP, 32'h0);
			chk("step read", {10'h0, DRV_TAB[s], 2'h0, PAT_TAB[s], 2'h0, ISEL_TAB[s], 1'b0, 3'(s + 1)}, rd);
			chk("pattern", {26'h0, PAT_TAB[s]}, {26'h0, outputPattern});
			chk("select", {30'h0, ISEL_TAB[s]}, {30'h0, inputSelect});
			chk("driver", {26'h0, DRV_TAB[s]}, {26'h0, demagDriver});
			apb(1'b0, OFS_CTRL, 32'h0);
			chk("ctrl bits", {28'h0, s[0], 1'b1, 1'b0, s[0]}, {28'h0, rd[6:3]});
		end
		apb(1'b1, OFS_STEP, 32'h0);
		apb(1'b0, OFS_STEP, 32'h0);
		chk("step zero", 32'h6, {29'h0, rd[2:0]});
		apb(1'b1, OFS_CTRL, 32'h00A4);
		apb(1'b1, OFS_MASK, 32'h3);
		apb(1'b1, OFS_STEP, 32'h1);
		chk("reference", 32'h2, {30'h0, referenceSelect});
		evt(100, 100, -1);
		win("hw demag time", tD, 100, 125);
		win("zero time", tZ, 200, 230);
		apb(1'b0, OFS_DEMAG, 32'h0);
		win("capture", int'(rd), 24, 32);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", 32'h3, rd);
		chk("irq set", 32'h1, {31'h0, irqReq});
		apb(1'b1, OFS_STATUS, 32'h3);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status clear", 32'h0, rd);
		chk("irq clear", 32'h0, {31'h0, irqReq});
		// Demag edge inside the blank is lost, so neither event may follow
		evt(5, 60, -1);
		win("blanked demag", tD, -1, -1);
		win("no early zero", tZ, -1, -1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("wait demag", 32'h4, rd);
		apb(1'b1, OFS_CTRL, 32'h00C4);
		evt(40, 200, 20);
		win("sw demag time", tD, 70, 100);
		win("zero after sw", tZ, 240, 275);
		evenStep <= 1'b1;
		apb(1'b1, OFS_STEP, 32'h2);
		evt(40, 100, 60);
		win("first demag", tD, 40, 65);
		win("rising zero", tZ, 140, 175);
		evenStep <= 1'b0;
		apb(1'b1, OFS_STEP, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h0024);
		evt(40, 60, -1);
		win("gate demag", tD, 40, 65);
		win("group gate", tZ, -1, -1);
		apb(1'b1, OFS_CTRL, 32'h0005);
		evt(40, 60, -1);
		chk("sensor mode", 32'h1, {31'h0, sensorMode});
		win("sensor no demag", tD, -1, -1);
		win("sensor zero", tZ, 100, 125);
		// Level bit set with edge bit set keeps a falling zero crossing
		apb(1'b1, OFS_CTRL, 32'h00BC);
		evt(40, 60, -1);
		win("level demag", tD, 40, 65);
		win("level zero", tZ, 100, 125);
		// Current mode on the even group, window rate 0 gives a 16-cycle tick
		pwmEvenActive <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h0124);
		evt(40, 60, -1);
		win("window demag", tD, 40, 65);
		win("window zero", tZ, 100, 125);
		tally_and_finish();
	end
endmodule : bemf_demag_event_detector_tb_top
